//--- arsf_pkg.sv
package arsf_pkg;

  // Register byte offsets, low address byte only (upper bits alias)
  localparam logic [7:0] OFS_EN_SET   = 8'h00;
  localparam logic [7:0] OFS_EN_CLR   = 8'h04;
  localparam logic [7:0] OFS_EN_STAT  = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_LAST     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_RES_BASE = 8'h20;

  // Status word field positions
  localparam int ST_DONE_LSB = 0;
  localparam int ST_OVR_LSB  = 8;
  localparam int ST_RDY_BIT  = 16;
  localparam int ST_GOVR_BIT = 17;

  // Interrupt status and mask bit positions
  localparam int IRQ_RES_BIT = 0;
  localparam int IRQ_OVR_BIT = 1;
  localparam int IRQ_W       = 2;

  // Defaults and limits of the parameters
  localparam int DEF_CHANNELS = 8;
  localparam int MAX_CHANNELS = 8;
  localparam int DEF_DATA_W   = 10;
  localparam int MAX_DATA_W   = 16;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Bus access sequencer, Gray along idle, access, answer
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_ACCESS = 2'b01,
    BUS_ANSWER = 2'b11
  } arsf_bus_t;

endpackage : arsf_pkg

//--- arsf_flag_if.sv
`timescale 1ns/1ps
interface arsf_flag_if #(
  parameter int N  = 8,
  parameter int CW = 3
);
  logic          eoc;       // End of conversion pulse
  logic [CW-1:0] eoc_chan;  // Channel of that conversion
  logic [N-1:0]  chan_en;   // Enabled channels
  logic [N-1:0]  dis_now;   // Channels being disabled this cycle
  logic          rd_chan;   // Channel result read pulse
  logic [CW-1:0] rd_idx;    // Channel of that read
  logic          rd_last;   // Last result read pulse
  logic          rd_status; // Status read pulse
  logic [N-1:0]  done;      // Conversion-done flags
  logic [N-1:0]  ovr;       // Channel overrun flags
  logic          rdy;       // Result-ready flag
  logic          govr;      // Any-overrun flag
  logic          eoc_ok;    // Conversion accepted this cycle
  logic          ovr_evt;   // Some overrun set this cycle

  modport core (
    input  eoc, eoc_chan, chan_en, dis_now, rd_chan, rd_idx, rd_last, rd_status,
    output done, ovr, rdy, govr, eoc_ok, ovr_evt
  );
  modport regs (
    output eoc, eoc_chan, chan_en, dis_now, rd_chan, rd_idx, rd_last, rd_status,
    input  done, ovr, rdy, govr, eoc_ok, ovr_evt
  );
endinterface : arsf_flag_if

//--- arsf_flag_core.sv
`timescale 1ns/1ps
module arsf_flag_core #(
  parameter int N  = 8,
  parameter int CW = 3
) (
  input logic        hclk,    // System clock
  input logic        hresetn, // Async reset, active low
  arsf_flag_if.core  f        // Events in, flags out
);

  // One-hot of a channel number, shared by read and conversion decode
  function automatic logic [N-1:0] onehot(input logic [CW-1:0] idx);
    onehot = '0;
    onehot[idx] = 1'b1;
  endfunction : onehot

  logic [N-1:0] done_r;
  logic [N-1:0] ovr_r;
  logic         rdy_r;
  logic         govr_r;

  // Conversions on disabled channels, or ones being disabled now, are dropped
  wire [N-1:0] eoc_hot  = onehot(f.eoc_chan);
  wire         eoc_ok_w = f.eoc & |(eoc_hot & f.chan_en & ~f.dis_now); // [RULE2] [RULE12]

  // Done flags: set by own conversion, cleared by own or last-result read
  wire [N-1:0] set_done = {N{eoc_ok_w}} & eoc_hot; // [RULE15]
  wire [N-1:0] clr_done = ({N{f.rd_chan}} & onehot(f.rd_idx)) | {N{f.rd_last}}; // [RULE11] [RULE13]
  wire [N-1:0] done_nxt = set_done | (done_r & ~clr_done);

  // Channel overrun: new result on top of an unread one; set beats clear
  wire [N-1:0] ovr_set  = set_done & done_r; // [RULE9]
  wire [N-1:0] ovr_nxt  = ovr_set | (ovr_r & ~{N{f.rd_status}}); // [RULE10]

  // Ready falls only on a last-result read; a new result always raises it
  wire         rdy_nxt  = eoc_ok_w | (rdy_r & ~f.rd_last); // [RULE1] [RULE3] [RULE4]

  // Any-overrun: set wins over the status-read clear in the same cycle
  wire         govr_set = eoc_ok_w & rdy_r; // [RULE5] [RULE7] [RULE8]
  wire         govr_nxt = govr_set | (govr_r & ~f.rd_status); // [RULE6]

  // Flag registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= '0;
      ovr_r  <= '0;
      rdy_r  <= 1'b0;
      govr_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      ovr_r  <= ovr_nxt;
      rdy_r  <= rdy_nxt;
      govr_r <= govr_nxt;
    end
  end

  assign f.done    = done_r;
  assign f.ovr     = ovr_r;
  assign f.rdy     = rdy_r;
  assign f.govr    = govr_r;
  assign f.eoc_ok  = eoc_ok_w;
  assign f.ovr_evt = govr_set | (|ovr_set);

  // Checks on the flag behaviour
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ready_fall_cause: assert property ($fell(rdy_r) |-> $past(f.rd_last)) // [RULE1]
    else $error("ready flag fell without a last-result read");
  a_drop_disabled: assert property ((f.eoc && !eoc_ok_w && (f.rd_last || !rdy_r)) // [RULE2]
    |=> !rdy_r)
    else $error("ready flag set by a dropped conversion");
  a_ready_on_result: assert property (eoc_ok_w |=> rdy_r) // [RULE3] [RULE15]
    else $error("ready flag not set by accepted conversion");
  a_ready_disable: assert property ((eoc_ok_w && |f.dis_now) |=> rdy_r) // [RULE4]
    else $error("ready flag lost while another channel was disabled");
  a_govr_set: assert property ((eoc_ok_w && rdy_r) |=> govr_r) // [RULE5]
    else $error("any-overrun not set on result over ready data");
  a_govr_read_set: assert property ((eoc_ok_w && rdy_r && f.rd_status) |=> govr_r) // [RULE6]
    else $error("any-overrun set lost to status read");
  a_govr_clear: assert property ((f.rd_status && !(eoc_ok_w && rdy_r)) |=> !govr_r) // [RULE6]
    else $error("any-overrun not cleared by status read");
  a_govr_chan_rd: assert property ((eoc_ok_w && rdy_r && f.rd_chan) |=> govr_r) // [RULE7]
    else $error("any-overrun lost to a channel result read");
  a_govr_disable: assert property ((eoc_ok_w && rdy_r && |f.dis_now) |=> govr_r) // [RULE8]
    else $error("any-overrun lost to a channel disable");
  a_chan_ovr_set: assert property ((|ovr_set) // [RULE9]
    |=> (ovr_r & $past(ovr_set)) == $past(ovr_set))
    else $error("channel overrun not set");
  a_chan_ovr_clear: assert property ((f.rd_status && ovr_set == '0) |=> ovr_r == '0) // [RULE10]
    else $error("channel overrun not cleared by status read");
  a_done_last_clr: assert property ((f.rd_last && !eoc_ok_w) |=> done_r == '0) // [RULE11]
    else $error("done flags not cleared by last-result read");
  a_done_dropped: assert property ((f.eoc && !eoc_ok_w) // [RULE12]
    |=> (done_r & ~$past(done_r)) == '0)
    else $error("done flag set by a dropped conversion");
  a_done_others: assert property ((f.rd_chan && !f.rd_last) // [RULE13]
    |=> ($past(done_r) & ~onehot($past(f.rd_idx)) & ~done_r) == '0)
    else $error("channel read disturbed another done flag");

  c_read_and_result: cover property (eoc_ok_w && f.rd_chan);
  c_dropped_result:  cover property (f.eoc && !eoc_ok_w && f.rd_last);
  c_overrun_read:    cover property (eoc_ok_w && rdy_r && f.rd_status);
  c_disable_result:  cover property (eoc_ok_w && |f.dis_now);

endmodule : arsf_flag_core

//--- arsf_status_top.sv
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// RULE1 - Result-ready clears only on last-result read, never on channel result reads.
// RULE2 - Conversion on a disabled channel stores nothing and never raises result-ready.
// RULE3 - Channel read during another enabled channel's conversion still raises result-ready.
// RULE4 - Disable of one channel during another's conversion still stores and raises ready.
// RULE5 - Conversion ending while result-ready is high sets any-overrun.
// RULE6 - Status read clears any-overrun; a coincident new overrun sets it.
// RULE7 - Any-overrun is set even when another channel's result is read.
// RULE8 - Any-overrun is set even when another channel is being disabled.
// RULE9 - Conversion over a channel's still-set done flag sets its overrun flag.
// RULE10 - Status read clears channel overrun flags even while done is being set.
// RULE11 - Channel or last-result read clears that channel's done flag. Here a last-result read clears every done flag.
// RULE12 - A disabled channel's done flag never rises, whatever reads coincide.
// RULE13 - A channel read clears only its own done flag.
// RULE14 - Software ignores done of disabled channels; avoids mixing ready polling with reads.
// RULE15 - Accepted conversion writes channel and last result, sets done and ready.
module arsf_status_top #(
  parameter int N      = arsf_pkg::DEF_CHANNELS,
  parameter int DATA_W = arsf_pkg::DEF_DATA_W
) (
  input  logic              hclk,      // System clock, 100 MHz
  input  logic              hresetn,   // Async reset, active low
  input  logic              hsel,      // Slave select
  input  logic [31:0]       haddr,     // Byte address
  input  logic [1:0]        htrans,    // Transfer type
  input  logic              hwrite,    // Write when high
  input  logic [2:0]        hsize,     // Word accesses only
  input  logic [31:0]       hwdata,    // Write data
  input  logic              hready,    // Bus ready in
  output logic              hreadyout, // Slave ready
  output logic [31:0]       hrdata,    // Read data
  output logic              hresp,     // Always OKAY
  input  logic              eoc,       // End of conversion pulse
  input  logic [2:0]        eoc_chan,  // Channel just converted
  input  logic [DATA_W-1:0] eoc_data,  // Conversion result
  output logic [N-1:0]      chan_en,   // Enabled channels to converter
  output logic              irq        // Level interrupt, active high
);

  localparam int CW = $clog2(N);

  // Elaboration checks on the parameters
  if (N < 2 || N > arsf_pkg::MAX_CHANNELS) begin : g_bad_n
    $error("channel count out of range");
  end
  if (DATA_W < 1 || DATA_W > arsf_pkg::MAX_DATA_W) begin : g_bad_w
    $error("result width out of range");
  end

  // Word match of the latched address against a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  arsf_pkg::arsf_bus_t state_r;
  arsf_pkg::arsf_bus_t state_nxt;

  logic [7:0]                     addr_r;
  logic                           wr_r;
  logic                           hreadyout_r;
  logic [31:0]                    hrdata_r;
  logic                           hresp_r;
  logic [N-1:0]                   chan_en_r;
  logic [DATA_W-1:0]              res_r [N];
  logic [DATA_W-1:0]              last_r;
  logic [arsf_pkg::IRQ_W-1:0]     irq_stat_r;
  logic [arsf_pkg::IRQ_W-1:0]     irq_mask_r;
  logic                           irq_r;
  logic [31:0]                    rd_mux;

  arsf_flag_if #(.N(N), .CW(CW)) flg ();

  arsf_flag_core #(.N(N), .CW(CW)) u_core (
    .hclk    (hclk),
    .hresetn (hresetn),
    .f       (flg.core)
  );

  // Address phase is taken only while the bus is ready
  wire take   = hsel & htrans[1] & hready;
  wire acc    = (state_r == arsf_pkg::BUS_ACCESS);
  wire rd_acc = acc & ~wr_r;
  wire wr_acc = acc & wr_r;

  // Sequencer: one wait state so read data and side effects share an edge
  always_comb begin
    case (state_r)
      arsf_pkg::BUS_IDLE:   state_nxt = take ? arsf_pkg::BUS_ACCESS : arsf_pkg::BUS_IDLE;
      arsf_pkg::BUS_ACCESS: state_nxt = arsf_pkg::BUS_ANSWER;
      arsf_pkg::BUS_ANSWER: state_nxt = take ? arsf_pkg::BUS_ACCESS : arsf_pkg::BUS_IDLE;
      default:              state_nxt = arsf_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= arsf_pkg::BUS_IDLE;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      hreadyout_r <= (state_nxt != arsf_pkg::BUS_ACCESS);
      hresp_r     <= 1'b0;
    end
  end

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_r   <= 1'b0;
    end else if (take && state_r != arsf_pkg::BUS_ACCESS) begin
      addr_r <= haddr[7:0];
      wr_r   <= hwrite;
    end
  end

  // Register decode
  wire hit_en_set = hit(addr_r, arsf_pkg::OFS_EN_SET);
  wire hit_en_clr = hit(addr_r, arsf_pkg::OFS_EN_CLR);
  wire hit_en_st  = hit(addr_r, arsf_pkg::OFS_EN_STAT);
  wire hit_status = hit(addr_r, arsf_pkg::OFS_STATUS);
  wire hit_last   = hit(addr_r, arsf_pkg::OFS_LAST);
  wire hit_istat  = hit(addr_r, arsf_pkg::OFS_IRQ_STAT);
  wire hit_imask  = hit(addr_r, arsf_pkg::OFS_IRQ_MASK);
  wire hit_res    = (addr_r[7:5] == arsf_pkg::OFS_RES_BASE[7:5])
                  && (int'(addr_r[4:2]) < N);
  wire [CW-1:0] res_idx = addr_r[2 +: CW];

  // Read side effects reach the flag core in the access cycle
  assign flg.eoc       = eoc & (int'(eoc_chan) < N); // Out-of-range channels never reach flags
  assign flg.eoc_chan  = eoc_chan[CW-1:0];
  assign flg.chan_en   = chan_en_r;
  assign flg.rd_chan   = rd_acc & hit_res;   // [RULE13]
  assign flg.rd_idx    = res_idx;
  assign flg.rd_last   = rd_acc & hit_last;  // [RULE1] [RULE11]
  assign flg.rd_status = rd_acc & hit_status; // [RULE6] [RULE10]

  // A disable write takes effect on conversions ending in the same cycle
  wire [N-1:0] en_set_w = (wr_acc & hit_en_set) ? hwdata[N-1:0] : '0;
  wire [N-1:0] en_clr_w = (wr_acc & hit_en_clr) ? hwdata[N-1:0] : '0;
  assign flg.dis_now   = en_clr_w; // [RULE2] [RULE12]

  // Channels beyond N would alias a real channel, so they are dropped here
  wire eoc_in_range = (int'(eoc_chan) < N);
  wire store        = flg.eoc_ok & eoc_in_range;

  // Channel enable register, disable wins over enable in one write pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_en_r <= '0;
    end else begin
      chan_en_r <= (chan_en_r | en_set_w) & ~en_clr_w;
    end
  end

  // Per-channel result storage, written only for accepted conversions
  for (genvar i = 0; i < N; i++) begin : g_res
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        res_r[i] <= '0;
      end else if (store && eoc_chan[CW-1:0] == CW'(i)) begin // [RULE4] [RULE15]
        res_r[i] <= eoc_data;
      end
    end
  end

  // Last result mirrors whichever channel's conversion was accepted most recently
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_r <= '0;
    end else if (store) begin // [RULE2] [RULE15]
      last_r <= eoc_data;
    end
  end

  // Interrupt events: accepted result and any overrun
  wire [arsf_pkg::IRQ_W-1:0] irq_evt = {flg.ovr_evt, store};
  wire [arsf_pkg::IRQ_W-1:0] irq_w1c = (wr_acc & hit_istat)
                                     ? hwdata[arsf_pkg::IRQ_W-1:0] : '0;
  wire [arsf_pkg::IRQ_W-1:0] irq_stat_nxt = irq_evt | (irq_stat_r & ~irq_w1c);
  wire [arsf_pkg::IRQ_W-1:0] irq_mask_nxt = (wr_acc & hit_imask)
                                          ? hwdata[arsf_pkg::IRQ_W-1:0] : irq_mask_r;

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r      <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  // Status word assembly
  wire [31:0] status_w = (32'(flg.done) << arsf_pkg::ST_DONE_LSB)
                       | (32'(flg.ovr)  << arsf_pkg::ST_OVR_LSB)
                       | (32'(flg.rdy)  << arsf_pkg::ST_RDY_BIT)
                       | (32'(flg.govr) << arsf_pkg::ST_GOVR_BIT);

  // Read mux; unmapped and write-only offsets read as zero
  always_comb begin
    rd_mux = arsf_pkg::RST_WORD;
    if (hit_en_st) begin
      rd_mux = 32'(chan_en_r);
    end else if (hit_status) begin
      rd_mux = status_w;
    end else if (hit_last) begin
      rd_mux = 32'(last_r);
    end else if (hit_istat) begin
      rd_mux = 32'(irq_stat_r);
    end else if (hit_imask) begin
      rd_mux = 32'(irq_mask_r);
    end else if (hit_res) begin
      rd_mux = 32'(res_r[res_idx]);
    end
  end

  // Read data captured with the pre-clear flag values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= arsf_pkg::RST_WORD;
    end else if (rd_acc) begin
      hrdata_r <= rd_mux;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata    = hrdata_r;
  assign hresp     = hresp_r;
  assign chan_en   = chan_en_r;
  assign irq       = irq_r;

  // Bus and storage checks
  a_one_wait_state: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && state_r != arsf_pkg::BUS_ACCESS) |=> !hreadyout_r ##1 hreadyout_r)
    else $error("access did not answer after exactly one wait state");
  a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hready |-> !hresp_r)
    else $error("slave answered other than OKAY");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_r == |(irq_stat_r & irq_mask_r))
    else $error("interrupt level disagrees with masked status");
  a_last_result: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
    store |=> last_r == $past(eoc_data))
    else $error("last result not written by accepted conversion");
  a_no_store_off: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
    (eoc && !store) |=> $stable(last_r))
    else $error("dropped conversion changed the last result");
  a_chan_result: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
    (store && |flg.dis_now) |=> res_r[$past(eoc_chan[CW-1:0])] == $past(eoc_data))
    else $error("channel result lost during a disable");

  // Flag outcomes seen from the bus side, so a broken core link shows up here too
  a_store_ready: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
    (store && flg.rd_chan) |=> flg.rdy)
    else $error("channel read suppressed the result-ready flag");
  a_store_govr: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE5] [RULE7]
    (store && flg.rdy) |=> flg.govr)
    else $error("result over ready data did not set any-overrun");
  a_disable_govr: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
    (store && flg.rdy && |flg.dis_now) |=> flg.govr)
    else $error("any-overrun lost while a channel was disabled");
  a_store_ovr: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
    (store && flg.done[flg.eoc_chan]) |=> flg.ovr[$past(flg.eoc_chan)])
    else $error("result over unread channel did not set its overrun");
  a_store_chan: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
    store |=> res_r[$past(flg.eoc_chan)] == $past(eoc_data))
    else $error("channel result not written by accepted conversion");
  a_drop_chan: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
    (eoc && !store) |=> res_r[$past(flg.eoc_chan)] == $past(res_r[flg.eoc_chan]))
    else $error("dropped conversion changed a channel result");
  a_status_rdclr: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE6] [RULE10]
    (flg.rd_status && !store) |=> !flg.govr && flg.ovr == '0)
    else $error("status read left an overrun flag set");
  a_last_rdclr: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1] [RULE11]
    (flg.rd_last && !store) |=> !flg.rdy && flg.done == '0)
    else $error("last-result read left ready or done set");
  a_chan_rdclr: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11] [RULE13]
    (flg.rd_chan && !store) |=> !flg.done[$past(flg.rd_idx)])
    else $error("channel read left its own done flag set");
  a_en_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
    (|en_clr_w) |=> (chan_en_r & $past(en_clr_w)) == '0)
    else $error("disable write left a channel enabled");
  a_en_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (|en_set_w) |=> (chan_en_r & $past(en_set_w)) == $past(en_set_w))
    else $error("enable write did not enable its channels");
  a_hrdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_acc |=> $stable(hrdata_r))
    else $error("read data changed outside a read access");
  a_irq_result: assert property (@(posedge hclk) disable iff (!hresetn)
    (store && irq_mask_r[arsf_pkg::IRQ_RES_BIT] && !(wr_acc && hit_imask)) |=> irq_r)
    else $error("unmasked result event did not raise the interrupt");

  c_status_read: cover property (@(posedge hclk) disable iff (!hresetn)
    flg.rd_status && flg.govr);

endmodule : arsf_status_top

//--- arsf_status_top_bench.sv
`timescale 1ns/1ps
module arsf_status_top_bench;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] wd;
    logic [31:0] exp;
  } arsf_row_t;

  // Short offset names
  localparam logic [7:0] O_ST   = arsf_pkg::OFS_STATUS;
  localparam logic [7:0] O_LAST = arsf_pkg::OFS_LAST;
  localparam logic [7:0] O_CLR  = arsf_pkg::OFS_EN_CLR;
  localparam logic [7:0] O_IRQ  = arsf_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] O_RES  = arsf_pkg::OFS_RES_BASE;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        eoc;
  logic [2:0]  eoc_chan;
  logic [9:0]  eoc_data;
  logic [7:0]  chan_en;
  logic        irq;
  int          mismatches;
  int          n_checks;

  // Plain register traffic, reset values first; 0x1C is unmapped
  arsf_row_t rows [0:16] = '{
    '{1'b0, arsf_pkg::OFS_EN_STAT, 32'h0, 32'h0}, '{1'b0, O_ST, 32'h0, 32'h0},
    '{1'b0, O_LAST, 32'h0, 32'h0}, '{1'b0, O_IRQ, 32'h0, 32'h0},
    '{1'b0, arsf_pkg::OFS_IRQ_MASK, 32'h0, 32'h0}, '{1'b0, 8'h1C, 32'h0, 32'h0},
    '{1'b0, O_RES, 32'h0, 32'h0}, '{1'b1, arsf_pkg::OFS_EN_SET, 32'hFF, 32'h0},
    '{1'b0, arsf_pkg::OFS_EN_STAT, 32'h0, 32'hFF}, '{1'b1, O_CLR, 32'h80, 32'h0},
    '{1'b0, arsf_pkg::OFS_EN_STAT, 32'h0, 32'h7F},
    '{1'b1, arsf_pkg::OFS_IRQ_MASK, 32'h3, 32'h0},
    '{1'b0, arsf_pkg::OFS_IRQ_MASK, 32'h0, 32'h3}, '{1'b1, 8'h1C, 32'hFFFF_FFFF, 32'h0},
    '{1'b0, 8'h1C, 32'h0, 32'h0}, '{1'b1, O_ST, 32'hFFFF_FFFF, 32'h0},
    '{1'b0, O_ST, 32'h0, 32'h0}
  };

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  arsf_status_top #(
    .N      (8),
    .DATA_W (10)
  ) DUT (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .eoc       (eoc),
    .eoc_chan  (eoc_chan),
    .eoc_data  (eoc_data),
    .chan_en   (chan_en),
    .irq       (irq)
  );

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One word access; ev fires a conversion on the data-phase edge so both coincide
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] wd,
                    input logic ev, input logic [2:0] ch, input logic [9:0] d,
                    input logic [31:0] exp);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    // Address phase stands until the bus is ready; only the watchdog ends a hang
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    htrans   <= 2'b00;
    hwdata   <= wd;
    eoc      <= ev;
    eoc_chan <= ch;
    eoc_data <= d;
    @(posedge hclk);
    eoc <= 1'b0;
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    if (!w) begin
      chk(hrdata, exp);
    end
  endtask : op

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    op(1'b0, a, 32'h0, 1'b0, 3'h0, 10'h0, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    op(1'b1, a, wd, 1'b0, 3'h0, 10'h0, 32'h0);
  endtask : wr

  // Lone conversion with an idle cycle after, so eoc never toggles twice per step
  task automatic conv(input logic [2:0] ch, input logic [9:0] d);
    eoc      <= 1'b1;
    eoc_chan <= ch;
    eoc_data <= d;
    @(posedge hclk);
    eoc <= 1'b0;
    @(posedge hclk);
  endtask : conv

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    complete_run();
  end

  initial begin
    mismatches = 0;
    n_checks   = 0;
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h0;
    eoc        = 1'b0;
    eoc_chan   = 3'h0;
    eoc_data   = 10'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk({22'h0, irq, hreadyout, chan_en}, 32'h100);
    $display("test reset done");
    foreach (rows[i]) begin
      op(rows[i].w, rows[i].a, rows[i].wd, 1'b0, 3'h0, 10'h0, rows[i].exp);
    end
    chk({24'h0, chan_en}, 32'h7F);
    $display("test registers done");
    conv(3'd1, 10'h155);
    rd(O_ST, 32'h0001_0002);
    rd(O_RES + 8'h04, 32'h155);
    rd(O_ST, 32'h0001_0000);
    rd(O_LAST, 32'h155);
    rd(O_ST, 32'h0);
    $display("test basic done");
    op(1'b0, O_RES + 8'h14, 32'h0, 1'b1, 3'd2, 10'h0AA, 32'h0);
    rd(O_ST, 32'h0001_0004);
    op(1'b0, O_RES + 8'h14, 32'h0, 1'b1, 3'd2, 10'h0BB, 32'h0);
    rd(O_ST, 32'h0003_0404);
    op(1'b0, O_ST, 32'h0, 1'b1, 3'd2, 10'h0CC, 32'h0001_0004);
    rd(O_ST, 32'h0003_0404);
    conv(3'd2, 10'h0DD);
    rd(O_RES + 8'h08, 32'h0DD);
    op(1'b0, O_ST, 32'h0, 1'b1, 3'd2, 10'h0EE, 32'h0003_0400);
    rd(O_ST, 32'h0003_0004);
    rd(O_ST, 32'h0001_0004);
    rd(O_LAST, 32'h0EE);
    rd(O_ST, 32'h0);
    $display("test overrun done");
    op(1'b1, O_CLR, 32'h08, 1'b1, 3'd3, 10'h111, 32'h0);
    op(1'b0, O_LAST, 32'h0, 1'b1, 3'd7, 10'h222, 32'h0EE);
    op(1'b0, O_RES, 32'h0, 1'b1, 3'd3, 10'h333, 32'h0);
    rd(O_ST, 32'h0);
    rd(O_LAST, 32'h0EE);
    rd(O_RES + 8'h0C, 32'h0);
    conv(3'd4, 10'h044);
    op(1'b1, O_CLR, 32'h02, 1'b1, 3'd4, 10'h055, 32'h0);
    rd(O_ST, 32'h0003_1010);
    rd(O_RES + 8'h10, 32'h055);
    rd(arsf_pkg::OFS_EN_STAT, 32'h75);
    conv(3'd0, 10'h100);
    conv(3'd5, 10'h105);
    op(1'b0, O_RES, 32'h0, 1'b1, 3'd6, 10'h106, 32'h100);
    rd(O_ST, 32'h0003_0060);
    rd(O_LAST, 32'h106);
    rd(O_ST, 32'h0);
    $display("test disable done");
    chk({31'h0, irq}, 32'h1);
    rd(O_IRQ, 32'h3);
    wr(O_IRQ, 32'h3);
    chk({31'h0, irq}, 32'h0);
    rd(O_IRQ, 32'h0);
    wr(arsf_pkg::OFS_IRQ_MASK, 32'h1);
    conv(3'd0, 10'h001);
    rd(O_IRQ, 32'h1);
    chk({31'h0, irq}, 32'h1);
    conv(3'd0, 10'h002);
    wr(O_IRQ, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(O_IRQ, 32'h2);
    $display("test interrupt done");
    // Reset in mid-run: outputs and registers fall back, bus usable right after
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({22'h0, irq, hreadyout, chan_en}, 32'h100);
    hresetn <= 1'b1;
    rd(arsf_pkg::OFS_IRQ_MASK, 32'h0);
    rd(O_LAST, 32'h0);
    rd(O_ST, 32'h0);
    $display("test reset again done");
    complete_run();
  end
endmodule : arsf_status_top_bench
